/* rtl/icm_pkg.sv */
// Constants for the ingress classification and meter configuration block.
package icm_pkg;
    // Forwarding class codes.
    localparam logic [2:0] FC_BEST_EFFORT = 3'h0;
    localparam logic [2:0] FC_LOW_TWO = 3'h1;
    localparam logic [2:0] FC_ASSURED = 3'h2;
    localparam logic [2:0] FC_LOW_ONE = 3'h3;
    localparam logic [2:0] FC_HIGH_TWO = 3'h4;
    localparam logic [2:0] FC_EXPEDITED = 3'h5;
    localparam logic [2:0] FC_HIGH_ONE = 3'h6;
    localparam logic [2:0] FC_NETWORK_CTRL = 3'h7;
    // Class selector names and their code point values.
    localparam logic [1:0] NAME_CLASS_SEL_ONE = 2'h1;
    localparam logic [1:0] NAME_CLASS_SEL_TWO = 2'h2;
    localparam logic [1:0] NAME_CLASS_SEL_THREE = 2'h3;
    localparam logic [5:0] CLASS_SEL_ONE_VAL = 6'h08;
    localparam logic [5:0] CLASS_SEL_TWO_VAL = 6'h10;
    localparam logic [5:0] CLASS_SEL_THREE_VAL = 6'h18;
    // Rate adaptation rule codes; none behaves as closest.
    localparam logic [1:0] ADAPT_NONE = 2'h0;
    localparam logic [1:0] ADAPT_MAX = 2'h1;
    localparam logic [1:0] ADAPT_MIN = 2'h2;
    localparam logic [1:0] ADAPT_CLOSEST = 2'h3;
    // Rate step of 8 kbps, expressed as the low bits to clear.
    localparam int RATE_STEP_KBPS = 8;
    localparam logic [32:0] RATE_ROUND_UP = 33'h000000007;
    localparam logic [32:0] RATE_ROUND_HALF = 33'h000000004;
    localparam logic [31:0] RATE_MASK = 32'hFFFFFFF8;
    // Meter colour codes.
    localparam logic [1:0] COLOUR_GREEN = 2'h0;
    localparam logic [1:0] COLOUR_YELLOW = 2'h1;
    localparam logic [1:0] COLOUR_RED = 2'h2;
    // Burst size bounds in kilobits and bits per kilobit.
    localparam logic [21:0] CBS_MAX_SMALL = 22'h004000;
    localparam logic [21:0] CBS_MAX_LARGE = 22'h20C28F;
    localparam logic [31:0] BITS_PER_KBIT = 32'h000003E8;
    // Refill period: rate in kbps over one millisecond equals bits.
    localparam int CLK_PERIOD_NS = 5;
    localparam int REFILL_PERIOD_US = 1000;
    localparam int REFILL_CYC = REFILL_PERIOD_US * 1000 / CLK_PERIOD_NS;
endpackage

/* rtl/icm_ingress_class_map.sv */
// Ingress code point classifier, rate adaptation and two-rate meter.
`timescale 1ns/1ps
module icm_ingress_class_map #(
    parameter int REFILL_CYCLES = icm_pkg::REFILL_CYC,
    parameter logic [21:0] CBS_MAX = icm_pkg::CBS_MAX_SMALL
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cfg_dscp_wr,
    input wire logic cfg_dscp_del,
    input wire logic cfg_dscp_use_name,
    input wire logic [1:0] cfg_dscp_name,
    input wire logic [5:0] cfg_dscp_value,
    input wire logic cfg_exp_wr,
    input wire logic cfg_exp_del,
    input wire logic [2:0] cfg_exp_value,
    input wire logic [2:0] cfg_forwarding_class,
    input wire logic cfg_in_profile,
    input wire logic [2:0] cfg_default_class,
    input wire logic cfg_default_in,
    input wire logic [31:0] cfg_cir_kbps,
    input wire logic [31:0] cfg_pir_kbps,
    input wire logic [1:0] cfg_cir_rule,
    input wire logic [1:0] cfg_pir_rule,
    input wire logic [21:0] cfg_cbs_kbits,
    input wire logic [21:0] cfg_mbs_kbits,
    output logic cfg_reject,
    input wire logic pkt_valid,
    input wire logic pkt_is_lsp,
    input wire logic [5:0] pkt_dscp,
    input wire logic [2:0] pkt_exp,
    input wire logic [15:0] pkt_len_bytes,
    output logic cls_valid,
    output logic cls_hit,
    output logic [2:0] cls_forwarding_class,
    output logic cls_in_profile,
    output logic mtr_valid,
    output logic [1:0] mtr_colour,
    output logic mtr_in_profile,
    output logic mtr_drop,
    output logic [31:0] oper_cir_kbps,
    output logic [31:0] oper_pir_kbps,
    output logic [21:0] cbs_kbits_held
);
    // Rounds a rate to a multiple of 8 kbps under the given rule.
    function automatic logic [31:0] adapt(input logic [31:0] r,
                                          input logic [1:0] rule);
        logic [32:0] s;
        s = {1'b0, r};
        if (rule == icm_pkg::ADAPT_MIN) begin
            s = s + icm_pkg::RATE_ROUND_UP;
        end else if (rule != icm_pkg::ADAPT_MAX) begin
            s = s + icm_pkg::RATE_ROUND_HALF;
        end
        if (s[32]) begin
            s = {1'b0, icm_pkg::RATE_MASK};
        end
        return s[31:0] & icm_pkg::RATE_MASK;
    endfunction

    // Adds to a bucket and saturates at its capacity.
    function automatic logic [31:0] sat_add(input logic [31:0] b,
                                            input logic [31:0] a,
                                            input logic [31:0] cap);
        logic [32:0] s;
        s = {1'b0, b} + {1'b0, a};
        return (s > {1'b0, cap}) ? cap : s[31:0];
    endfunction

    // Accepts a class and profile pair only if the class allows it.
    function automatic logic profile_ok(input logic [2:0] fc,
                                        input logic in_p);
        logic ok;
        ok = 1'b1;
        if (fc == icm_pkg::FC_EXPEDITED || fc == icm_pkg::FC_HIGH_ONE ||
            fc == icm_pkg::FC_NETWORK_CTRL) begin
            ok = in_p;
        end else if (fc == icm_pkg::FC_BEST_EFFORT) begin
            ok = !in_p;
        end
        return ok;
    endfunction

    logic rst_meta_reg;
    logic rst_n_sync;
    logic [63:0] dscp_valid_reg;
    logic [2:0] dscp_class_mem [64];
    logic dscp_prof_mem [64];
    logic [7:0] exp_valid_reg;
    logic [2:0] exp_class_mem [8];
    logic exp_prof_mem [8];
    logic [31:0] refill_cnt_reg;
    logic [31:0] cbkt_reg;
    logic [31:0] pbkt_reg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    // Configuration decode.
    wire [5:0] name_value = (cfg_dscp_name == icm_pkg::NAME_CLASS_SEL_ONE) ?
        icm_pkg::CLASS_SEL_ONE_VAL :
        (cfg_dscp_name == icm_pkg::NAME_CLASS_SEL_TWO) ?
        icm_pkg::CLASS_SEL_TWO_VAL : icm_pkg::CLASS_SEL_THREE_VAL;
    wire [5:0] dscp_idx = cfg_dscp_use_name ? name_value : cfg_dscp_value;
    wire pair_ok = profile_ok(cfg_forwarding_class, cfg_in_profile);
    wire dscp_map = cfg_dscp_wr && !cfg_dscp_del;
    wire exp_map = cfg_exp_wr && !cfg_exp_del;
    wire reject_next = (dscp_map || exp_map) && !pair_ok;

    // Lookup.
    wire hit = pkt_is_lsp ? exp_valid_reg[pkt_exp] : dscp_valid_reg[pkt_dscp];
    wire [2:0] hit_class = pkt_is_lsp ? exp_class_mem[pkt_exp] :
        dscp_class_mem[pkt_dscp];
    wire hit_prof = pkt_is_lsp ? exp_prof_mem[pkt_exp] :
        dscp_prof_mem[pkt_dscp];

    // Meter decode.
    wire [31:0] len_bits = {13'h0000, pkt_len_bytes, 3'h0};
    wire [21:0] cbs_clamped = (cfg_cbs_kbits > CBS_MAX) ? CBS_MAX :
        cfg_cbs_kbits;
    wire [53:0] cbs_prod = cbs_kbits_held * icm_pkg::BITS_PER_KBIT;
    wire [53:0] mbs_prod = cfg_mbs_kbits * icm_pkg::BITS_PER_KBIT;
    wire [31:0] cbs_bits = cbs_prod[31:0];
    wire [31:0] mbs_bits = mbs_prod[31:0];
    wire tick = (refill_cnt_reg >= 32'(REFILL_CYCLES - 1));
    wire peak_short = pbkt_reg < len_bits;
    wire commit_short = cbkt_reg < len_bits;
    wire [1:0] colour_next = peak_short ? icm_pkg::COLOUR_RED :
        commit_short ? icm_pkg::COLOUR_YELLOW :
        icm_pkg::COLOUR_GREEN;
    wire take_peak = pkt_valid && !peak_short;
    wire take_commit = take_peak && !commit_short;
    wire [31:0] cbkt_used = take_commit ? cbkt_reg - len_bits : cbkt_reg;
    wire [31:0] pbkt_used = take_peak ? pbkt_reg - len_bits : pbkt_reg;
    wire [31:0] cbkt_next = sat_add(cbkt_used,
        tick ? oper_cir_kbps : 32'h00000000, cbs_bits);
    wire [31:0] pbkt_next = sat_add(pbkt_used,
        tick ? oper_pir_kbps : 32'h00000000, mbs_bits);

    always_ff @(posedge sys_clk) begin
        if (dscp_map && pair_ok) begin
            dscp_class_mem[dscp_idx] <= cfg_forwarding_class;
            dscp_prof_mem[dscp_idx] <= cfg_in_profile;
        end
        if (exp_map && pair_ok) begin
            exp_class_mem[cfg_exp_value] <= cfg_forwarding_class;
            exp_prof_mem[cfg_exp_value] <= cfg_in_profile;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            dscp_valid_reg <= 64'h0000000000000000;
            exp_valid_reg <= 8'h00;
            cfg_reject <= 1'b0;
        end else begin
            if (cfg_dscp_wr && (cfg_dscp_del || pair_ok)) begin
                dscp_valid_reg[dscp_idx] <= !cfg_dscp_del;
            end
            if (cfg_exp_wr && (cfg_exp_del || pair_ok)) begin
                exp_valid_reg[cfg_exp_value] <= !cfg_exp_del;
            end
            cfg_reject <= reject_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            cls_valid <= 1'b0;
            cls_hit <= 1'b0;
            cls_forwarding_class <= icm_pkg::FC_BEST_EFFORT;
            cls_in_profile <= 1'b0;
        end else begin
            cls_valid <= pkt_valid;
            cls_hit <= pkt_valid && hit;
            if (pkt_valid) begin
                cls_forwarding_class <= hit ? hit_class :
                    cfg_default_class;
                cls_in_profile <= hit ? hit_prof : cfg_default_in;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            oper_cir_kbps <= 32'h00000000;
            oper_pir_kbps <= 32'h00000000;
            cbs_kbits_held <= 22'h000000;
        end else begin
            oper_cir_kbps <= adapt(cfg_cir_kbps, cfg_cir_rule);
            oper_pir_kbps <= adapt(cfg_pir_kbps, cfg_pir_rule);
            cbs_kbits_held <= cbs_clamped;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            refill_cnt_reg <= 32'h00000000;
            cbkt_reg <= 32'h00000000;
            pbkt_reg <= 32'h00000000;
            mtr_valid <= 1'b0;
            mtr_colour <= icm_pkg::COLOUR_GREEN;
            mtr_in_profile <= 1'b0;
            mtr_drop <= 1'b0;
        end else begin
            refill_cnt_reg <= tick ? 32'h00000000 : refill_cnt_reg + 32'h1;
            cbkt_reg <= cbkt_next;
            pbkt_reg <= pbkt_next;
            mtr_valid <= pkt_valid;
            mtr_drop <= pkt_valid && peak_short;
            if (pkt_valid) begin
                mtr_colour <= colour_next;
                mtr_in_profile <= (colour_next ==
                    icm_pkg::COLOUR_GREEN);
            end
        end
    end
    chk_reject_high_out: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        (dscp_map && !cfg_in_profile &&
         cfg_forwarding_class == icm_pkg::FC_EXPEDITED) |=> cfg_reject)
        else $error("Out-of-profile expedited entry was accepted.");
    chk_reject_be_in: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        (exp_map && cfg_in_profile &&
         cfg_forwarding_class == icm_pkg::FC_BEST_EFFORT)
        |=> cfg_reject && exp_valid_reg[$past(cfg_exp_value)] ==
            $past(exp_valid_reg[cfg_exp_value]))
        else $error("In-profile best-effort entry was accepted.");
    chk_default_dscp_miss: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        (pkt_valid && !pkt_is_lsp && !dscp_valid_reg[pkt_dscp])
        |=> !cls_hit && cls_forwarding_class == $past(cfg_default_class)
            && cls_in_profile == $past(cfg_default_in))
        else $error("Unmapped code point missed the default action.");
    chk_default_exp_miss: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        (pkt_valid && pkt_is_lsp && !exp_valid_reg[pkt_exp])
        |=> cls_forwarding_class == $past(cfg_default_class))
        else $error("Unmapped experimental value missed the default.");
    chk_max_rounds_down: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        (cfg_cir_rule == icm_pkg::ADAPT_MAX) |=> oper_cir_kbps[2:0] == 3'h0
            && oper_cir_kbps <= $past(cfg_cir_kbps)
            && $past(cfg_cir_kbps) - oper_cir_kbps < 32'h8)
        else $error("Max rule did not round the committed rate down.");
    chk_min_rounds_up: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        (cfg_pir_rule == icm_pkg::ADAPT_MIN && cfg_pir_kbps < 32'hFFFF0000)
        |=> oper_pir_kbps[2:0] == 3'h0 && oper_pir_kbps >= $past(cfg_pir_kbps)
            && oper_pir_kbps - $past(cfg_pir_kbps) < 32'h8)
        else $error("Min rule did not round the peak rate up.");
    chk_closest_default: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        (cfg_cir_rule == icm_pkg::ADAPT_NONE && cfg_cir_kbps < 32'hFFFF0000)
        |=> oper_cir_kbps + 32'h4 > $past(cfg_cir_kbps)
            && oper_cir_kbps <= $past(cfg_cir_kbps) + 32'h4)
        else $error("Default rule did not pick the closest rate.");
    chk_red_dropped: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        (pkt_valid && pbkt_reg < len_bits)
        |=> mtr_colour == icm_pkg::COLOUR_RED && mtr_drop && !mtr_in_profile)
        else $error("Packet beyond the peak bucket was not dropped red.");
    chk_green_profile: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        mtr_valid |-> mtr_in_profile == (mtr_colour == icm_pkg::COLOUR_GREEN))
        else $error("Meter profile does not follow the colour.");
    chk_cbs_bound: assert property (
        @(posedge sys_clk) disable iff (!rst_n_sync)
        ##1 cbs_kbits_held <= CBS_MAX)
        else $error("Committed burst size exceeds its bound.");
endmodule

/* verification/icm_pkt_source.sv */
// Packet receive path model that presents one header per call.
`timescale 1ns/1ps
module icm_pkt_source (
    input wire logic sys_clk,
    output logic pkt_valid,
    output logic pkt_is_lsp,
    output logic [5:0] pkt_dscp,
    output logic [2:0] pkt_exp,
    output logic [15:0] pkt_len_bytes
);
    initial begin
        pkt_valid = 1'h0;
        pkt_is_lsp = 1'h0;
        pkt_dscp = 6'h00;
        pkt_exp = 3'h0;
        pkt_len_bytes = 16'h0000;
    end
    // Holds a header for one edge, then scrambles the idle fields.
    task automatic send(input logic lsp, input logic [5:0] dscp,
                        input logic [2:0] exp, input logic [15:0] len);
        @(posedge sys_clk);
        pkt_valid <= 1'h1;
        pkt_is_lsp <= lsp;
        pkt_dscp <= dscp;
        pkt_exp <= exp;
        pkt_len_bytes <= len;
        @(posedge sys_clk);
        pkt_valid <= 1'h0;
        pkt_is_lsp <= ~lsp;
        pkt_dscp <= ~dscp;
        pkt_exp <= ~exp;
        pkt_len_bytes <= ~len;
        #1;
    endtask
endmodule

/* verification/icm_ingress_class_map_tb.sv */
// Self-checking bench for the ingress classifier and meter.
`timescale 1ns/1ps
module icm_ingress_class_map_tb;
    localparam int REFILL = 16;
    localparam logic [5:0] DEF_VEC = {2'h2, 3'h1, 1'h0};
    logic sys_clk, nrst, cfg_dscp_wr, cfg_dscp_del, cfg_dscp_use_name;
    logic cfg_exp_wr, cfg_exp_del, cfg_in_profile, cfg_default_in;
    logic cfg_reject, pkt_valid, pkt_is_lsp, cls_valid, cls_hit;
    logic cls_in_profile, mtr_valid, mtr_in_profile, mtr_drop;
    logic [1:0] cfg_dscp_name, cfg_cir_rule, cfg_pir_rule, mtr_colour;
    logic [5:0] cfg_dscp_value, pkt_dscp;
    logic [2:0] cfg_exp_value, cfg_forwarding_class, cfg_default_class;
    logic [2:0] pkt_exp, cls_forwarding_class;
    logic [31:0] cfg_cir_kbps, cfg_pir_kbps, oper_cir_kbps, oper_pir_kbps;
    logic [21:0] cfg_cbs_kbits, cfg_mbs_kbits, cbs_kbits_held;
    logic [15:0] pkt_len_bytes;
    int err_count = 0;
    int n_tests = 0;
    wire [5:0] cls_vec = {cls_valid, cls_hit, cls_forwarding_class,
                          cls_in_profile};
    wire [4:0] mtr_vec = {mtr_valid, mtr_colour, mtr_in_profile, mtr_drop};
    icm_ingress_class_map #(
        .REFILL_CYCLES(REFILL)
    ) u_icm_ingress_class_map (
        .sys_clk, .nrst, .cfg_dscp_wr, .cfg_dscp_del, .cfg_dscp_use_name,
        .cfg_dscp_name, .cfg_dscp_value, .cfg_exp_wr, .cfg_exp_del,
        .cfg_exp_value, .cfg_forwarding_class, .cfg_in_profile,
        .cfg_default_class, .cfg_default_in, .cfg_cir_kbps, .cfg_pir_kbps,
        .cfg_cir_rule, .cfg_pir_rule, .cfg_cbs_kbits, .cfg_mbs_kbits,
        .cfg_reject, .pkt_valid, .pkt_is_lsp, .pkt_dscp, .pkt_exp,
        .pkt_len_bytes, .cls_valid, .cls_hit, .cls_forwarding_class,
        .cls_in_profile, .mtr_valid, .mtr_colour, .mtr_in_profile, .mtr_drop,
        .oper_cir_kbps, .oper_pir_kbps, .cbs_kbits_held
    );
    icm_pkt_source u_icm_pkt_source (
        .sys_clk, .pkt_valid, .pkt_is_lsp, .pkt_dscp, .pkt_exp, .pkt_len_bytes
    );
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic map_wr(input logic ex, input logic del,
                          input logic [1:0] nm, input logic [5:0] idx,
                          input logic [2:0] fc, input logic inp);
        @(posedge sys_clk);
        cfg_dscp_wr <= ~ex;
        cfg_exp_wr <= ex;
        cfg_dscp_del <= del;
        cfg_exp_del <= del;
        cfg_dscp_use_name <= (nm != 2'h0);
        cfg_dscp_name <= nm;
        cfg_dscp_value <= idx;
        cfg_exp_value <= idx[2:0];
        cfg_forwarding_class <= fc;
        cfg_in_profile <= inp;
        @(posedge sys_clk);
        cfg_dscp_wr <= 1'h0;
        cfg_exp_wr <= 1'h0;
        #1;
    endtask
    task automatic pkt(input logic lsp, input logic [5:0] dscp,
                       input logic [2:0] exp, input logic [15:0] len);
        u_icm_pkt_source.send(lsp, dscp, exp, len);
    endtask
    task automatic set_rates(input logic [31:0] cir, input logic [31:0] pir,
                             input logic [1:0] cr, input logic [1:0] pr);
        @(posedge sys_clk);
        cfg_cir_kbps <= cir;
        cfg_pir_kbps <= pir;
        cfg_cir_rule <= cr;
        cfg_pir_rule <= pr;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic t_names();
        for (int n = 1; n < 4; n++) begin
            map_wr(1'h0, 1'h0, 2'(n), 6'h00, 3'(n + 1), 1'h1);
            check(cfg_reject, 1'h0);
            pkt(1'h0, 6'(8 * n), 3'h0, 16'h0040);
            check(cls_vec, {2'h3, 3'(n + 1), 1'h1});
        end
        for (int c = 0; c < 8; c++) begin
            map_wr(1'h0, 1'h0, 2'h0, 6'(56 + c), 3'(c), c != 0);
            pkt(1'h0, 6'(56 + c), 3'h0, 16'h0040);
            check(cls_vec, {2'h3, 3'(c), c != 0});
        end
        pkt(1'h0, 6'h00, 3'h0, 16'h0040);
        check(cls_vec, DEF_VEC);
        $display("names done");
    endtask
    task automatic t_reject();
        for (int c = 5; c < 8; c++) begin
            map_wr(1'h0, 1'h0, 2'h0, 6'(32 + c), 3'(c), 1'h0);
            check(cfg_reject, 1'h1);
            pkt(1'h0, 6'(32 + c), 3'h0, 16'h0040);
            check(cls_vec, DEF_VEC);
        end
        map_wr(1'h0, 1'h0, 2'h0, 6'h20, 3'h0, 1'h1);
        check(cfg_reject, 1'h1);
        map_wr(1'h0, 1'h0, 2'h0, 6'h3D, 3'h5, 1'h0);
        check(cfg_reject, 1'h1);
        pkt(1'h0, 6'h3D, 3'h0, 16'h0040);
        check(cls_vec, {2'h3, 3'h5, 1'h1});
        map_wr(1'h0, 1'h0, 2'h0, 6'h38, 3'h0, 1'h1);
        check(cfg_reject, 1'h1);
        pkt(1'h0, 6'h38, 3'h0, 16'h0040);
        check(cls_vec, {2'h3, 3'h0, 1'h0});
        $display("reject done");
    endtask
    task automatic t_exp();
        pkt(1'h1, 6'h08, 3'h2, 16'h0040);
        check(cls_vec, DEF_VEC);
        for (int e = 0; e < 8; e++) begin
            map_wr(1'h1, 1'h0, 2'h0, 6'(e), 3'(7 - e), e != 7);
        end
        for (int e = 0; e < 8; e++) begin
            pkt(1'h1, 6'h08, 3'(e), 16'h0040);
            check(cls_vec, {2'h3, 3'(7 - e), e != 7});
        end
        map_wr(1'h1, 1'h1, 2'h0, 6'h03, 3'h0, 1'h0);
        pkt(1'h1, 6'h08, 3'h3, 16'h0040);
        check(cls_vec, DEF_VEC);
        map_wr(1'h1, 1'h0, 2'h0, 6'h00, 3'h0, 1'h1);
        check(cfg_reject, 1'h1);
        pkt(1'h1, 6'h08, 3'h0, 16'h0040);
        check(cls_vec, {2'h3, 3'h7, 1'h1});
        map_wr(1'h0, 1'h1, 2'h0, 6'h08, 3'h0, 1'h0);
        pkt(1'h0, 6'h08, 3'h3, 16'h0040);
        check(cls_vec, DEF_VEC);
        @(posedge sys_clk);
        cfg_default_class <= 3'h6;
        cfg_default_in <= 1'h1;
        pkt(1'h1, 6'h08, 3'h3, 16'h0040);
        check(cls_vec, {2'h2, 3'h6, 1'h1});
        $display("exp done");
    endtask
    task automatic t_rates();
        set_rates(32'h000003E9, 32'h000003E9, 2'h1, 2'h2);
        check(oper_cir_kbps, 32'h000003E8);
        check(oper_pir_kbps, 32'h000003F0);
        set_rates(32'h000003EB, 32'h000003EC, 2'h3, 2'h3);
        check(oper_cir_kbps, 32'h000003E8);
        check(oper_pir_kbps, 32'h000003F0);
        set_rates(32'h000003EB, 32'h000003ED, 2'h2, 2'h1);
        check(oper_cir_kbps, 32'h000003F0);
        check(oper_pir_kbps, 32'h000003E8);
        set_rates(32'h000003EB, 32'h000003ED, 2'h0, 2'h0);
        check(oper_cir_kbps, 32'h000003E8);
        check(oper_pir_kbps, 32'h000003F0);
        set_rates(32'hFFFFFFFF, 32'hFFFFFFFF, 2'h1, 2'h2);
        check(oper_cir_kbps, 32'hFFFFFFF8);
        check(oper_pir_kbps, 32'hFFFFFFF8);
        $display("rates done");
    endtask
    task automatic t_meter();
        pkt(1'h0, 6'h00, 3'h0, 16'h0001);
        check(mtr_vec, 5'h19);
        @(posedge sys_clk);
        cfg_cbs_kbits <= 22'h3FFFFF;
        repeat (2) @(posedge sys_clk);
        #1;
        check(cbs_kbits_held, 22'h004000);
        @(posedge sys_clk);
        cfg_cbs_kbits <= 22'h000001;
        cfg_mbs_kbits <= 22'h000004;
        set_rates(32'h000003E8, 32'h00000FA0, 2'h3, 2'h3);
        check(cbs_kbits_held, 22'h000001);
        repeat (5 * REFILL) @(posedge sys_clk);
        set_rates(32'h00000000, 32'h00000000, 2'h3, 2'h3);
        pkt(1'h0, 6'h00, 3'h0, 16'h0064);
        check(mtr_vec, 5'h12);
        for (int i = 0; i < 4; i++) begin
            pkt(1'h0, 6'h00, 3'h0, 16'h0064);
            check(mtr_vec, 5'h14);
        end
        pkt(1'h0, 6'h00, 3'h0, 16'h0064);
        check(mtr_vec, 5'h19);
        $display("meter done");
    endtask
    initial begin
        nrst = 1'h0;
        {cfg_dscp_wr, cfg_dscp_del, cfg_dscp_use_name, cfg_exp_wr} = 4'h0;
        {cfg_exp_del, cfg_in_profile, cfg_dscp_name} = 4'h0;
        cfg_dscp_value = 6'h00;
        {cfg_exp_value, cfg_forwarding_class} = 6'h00;
        cfg_default_class = 3'h1;
        cfg_default_in = 1'h0;
        {cfg_cir_rule, cfg_pir_rule} = 4'h0;
        {cfg_cir_kbps, cfg_pir_kbps} = 64'h0;
        {cfg_cbs_kbits, cfg_mbs_kbits} = 44'h0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        t_names();
        t_reject();
        t_exp();
        t_rates();
        t_meter();
        print_verdict();
    end
    initial begin
        #20000;
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
